/* File: logic/isoch_bridge_header_config.v */
// APB register bank holding the isochronous header fields of the second
// bridge channel and the receive commands of both bridge channels.
// Assumes an APB master on pclk and receive engines that pulse acknowledges.
`timescale 1ns/1ps
`include "isoch_bridge_regs.vh"
module isoch_bridge_header_config (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg [5:0] tx_source_id_second,
    output reg [7:0] tx_block_size_second,
    output reg [1:0] tx_fraction_count_second,
    output reg [5:0] tx_format_code_second,
    output reg tx_time_shift_flag_second,
    output reg [5:0] tx_channel_second,
    output reg [1:0] tx_speed_second,
    output reg tx_speed_reserved,
    input wire rx_started_a,
    input wire rx_stopped_a,
    input wire rx_started_b,
    input wire rx_stopped_b,
    output wire rx_start_req_a,
    output wire rx_stop_req_a,
    output wire rx_start_req_b,
    output wire rx_stop_req_b,
    output wire rx_running_a,
    output wire rx_running_b,
    input wire pkt_valid,
    input wire [5:0] pkt_channel,
    output wire rx_accept_a,
    output wire rx_accept_b
);

    // ------------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------------
    reg [15:0] hdr_word_q;
    reg [15:0] chan_speed_q;
    reg [5:0] rx_chan_a_q;
    reg [5:0] rx_chan_b_q;
    wire start_pend_a;
    wire stop_pend_a;
    wire start_pend_b;
    wire stop_pend_b;
    wire setup_access;
    wire wr_en;
    wire rd_en;
    wire hit_hdr;
    wire hit_cs;
    wire hit_rx;
    wire hit_any;
    reg [15:0] rd_mux;

    // The bank answers with no wait state, so the access phase is one cycle.
    assign setup_access = psel & ~penable;
    assign hit_hdr = (paddr == `OFS_TX_HEADER_WORD_A);
    assign hit_cs = (paddr == `OFS_TX_CHANNEL_SPEED);
    assign hit_rx = (paddr == `OFS_RECEIVE_SETUP);
    assign hit_any = hit_hdr | hit_cs | hit_rx;
    assign wr_en = psel & penable & pready & pwrite & hit_any;
    assign rd_en = setup_access & ~pwrite;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_access;
            pslverr <= setup_access & ~hit_any;
            if (rd_en) begin
                prdata <= {16'h0000, rd_mux};
            end else if (setup_access) begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Writes
    // ------------------------------------------------------------------------
    // Registers sit at four times their index, so no access straddles two words.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hdr_word_q <= `RST_TX_HEADER_WORD_A;
            chan_speed_q <= `RST_TX_CHANNEL_SPEED;
            rx_chan_a_q <= 6'h00;
            rx_chan_b_q <= 6'h00;
        end else if (wr_en) begin
            if (hit_hdr) begin
                hdr_word_q <= pwdata[15:0];
            end
            if (hit_cs) begin
                chan_speed_q <= {pwdata[15:1], 1'b0};
            end
            if (hit_rx) begin
                rx_chan_b_q <= pwdata[`RXCH_B_MSB:`RXCH_B_LSB];
                rx_chan_a_q <= pwdata[`RXCH_A_MSB:`RXCH_A_LSB];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    always @* begin
        rd_mux = 16'h0000;
        if (hit_hdr) begin
            rd_mux = hdr_word_q;
        end else if (hit_cs) begin
            rd_mux = {chan_speed_q[15:1], 1'b0};
        end else if (hit_rx) begin
            rd_mux = {start_pend_b, stop_pend_b, rx_chan_b_q,
                      start_pend_a, stop_pend_a, rx_chan_a_q};
        end
    end

    // ------------------------------------------------------------------------
    // Header fields toward the transmitter
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_source_id_second <= 6'h00;
            tx_block_size_second <= 8'h00;
            tx_fraction_count_second <= 2'h0;
            tx_format_code_second <= 6'h00;
            tx_time_shift_flag_second <= 1'b0;
            tx_channel_second <= 6'h00;
            tx_speed_second <= 2'h0;
            tx_speed_reserved <= 1'b0;
        end else begin
            tx_source_id_second <= hdr_word_q[`SID_MSB:`SID_LSB];
            tx_block_size_second <= hdr_word_q[`DBS_MSB:`DBS_LSB];
            tx_fraction_count_second <= hdr_word_q[`FN_MSB:`FN_LSB];
            tx_format_code_second <= chan_speed_q[`FMT_MSB:`FMT_LSB];
            tx_time_shift_flag_second <= chan_speed_q[`TSF_BIT];
            tx_channel_second <= chan_speed_q[`TXCH_MSB:`TXCH_LSB];
            tx_speed_second <= chan_speed_q[`SPD_MSB:`SPD_LSB];
            // Code 11 is flagged so the transmitter can refuse to send.
            tx_speed_reserved <= (chan_speed_q[`SPD_MSB:`SPD_LSB] == `SPEED_RSVD);
        end
    end

    // ------------------------------------------------------------------------
    // Receive commands
    // ------------------------------------------------------------------------
    wire set_start_b;
    wire set_stop_b;
    wire set_start_a;
    wire set_stop_a;
    assign set_start_b = wr_en & hit_rx & pwdata[`RX_START_B_BIT];
    assign set_stop_b = wr_en & hit_rx & pwdata[`RX_STOP_B_BIT];
    assign set_start_a = wr_en & hit_rx & pwdata[`RX_START_A_BIT];
    assign set_stop_a = wr_en & hit_rx & pwdata[`RX_STOP_A_BIT];

    rx_run_ctrl u_run_b (
        .pclk(pclk),
        .presetn(presetn),
        .start_set(set_start_b),
        .stop_set(set_stop_b),
        .start_ack(rx_started_b),
        .stop_ack(rx_stopped_b),
        .start_pend_q(start_pend_b),
        .stop_pend_q(stop_pend_b),
        .running_q(rx_running_b)
    );

    rx_run_ctrl u_run_a (
        .pclk(pclk),
        .presetn(presetn),
        .start_set(set_start_a),
        .stop_set(set_stop_a),
        .start_ack(rx_started_a),
        .stop_ack(rx_stopped_a),
        .start_pend_q(start_pend_a),
        .stop_pend_q(stop_pend_a),
        .running_q(rx_running_a)
    );

    assign rx_start_req_b = start_pend_b;
    assign rx_stop_req_b = stop_pend_b;
    assign rx_start_req_a = start_pend_a;
    assign rx_stop_req_a = stop_pend_a;

    // ------------------------------------------------------------------------
    // Channel filters
    // ------------------------------------------------------------------------
    chan_match #(.CH_W(6)) u_match_b (
        .pclk(pclk),
        .presetn(presetn),
        .enable(rx_running_b),
        .pkt_valid(pkt_valid),
        .pkt_channel(pkt_channel),
        .want_channel(rx_chan_b_q),
        .accept_q(rx_accept_b)
    );

    chan_match #(.CH_W(6)) u_match_a (
        .pclk(pclk),
        .presetn(presetn),
        .enable(rx_running_a),
        .pkt_valid(pkt_valid),
        .pkt_channel(pkt_channel),
        .want_channel(rx_chan_a_q),
        .accept_q(rx_accept_a)
    );

endmodule // isoch_bridge_header_config

/* File: logic/isoch_bridge_regs.vh */
// Register offsets, field positions and reset values of the bridge header bank.
// Assumes inclusion by bare name from the design modules.
`ifndef ISOCH_BRIDGE_REGS_VH
`define ISOCH_BRIDGE_REGS_VH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
// Each register sits at four times its index, so every access is one aligned word.
`define OFS_TX_HEADER_WORD_A 12'h0e0
`define OFS_TX_CHANNEL_SPEED 12'h0e8
`define OFS_RECEIVE_SETUP 12'h0f0
`define IDX_TX_HEADER_WORD_A 12'h038
`define IDX_TX_CHANNEL_SPEED 12'h03a
`define IDX_RECEIVE_SETUP 12'h03c

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_TX_HEADER_WORD_A 16'h0000
`define RST_TX_CHANNEL_SPEED 16'h0000
`define RST_RECEIVE_SETUP 16'h0000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SID_MSB 15
`define SID_LSB 10
`define DBS_MSB 9
`define DBS_LSB 2
`define FN_MSB 1
`define FN_LSB 0
`define FMT_MSB 15
`define FMT_LSB 10
`define TSF_BIT 9
`define TXCH_MSB 8
`define TXCH_LSB 3
`define SPD_MSB 2
`define SPD_LSB 1
`define RSV_BIT 0
`define RX_START_B_BIT 15
`define RX_STOP_B_BIT 14
`define RXCH_B_MSB 13
`define RXCH_B_LSB 8
`define RX_START_A_BIT 7
`define RX_STOP_A_BIT 6
`define RXCH_A_MSB 5
`define RXCH_A_LSB 0

// ----------------------------------------------------------------------------
// Speed codes
// ----------------------------------------------------------------------------
`define SPEED_100 2'h0
`define SPEED_200 2'h1
`define SPEED_400 2'h2
`define SPEED_RSVD 2'h3

`endif

/* File: logic/rx_run_ctrl.v */
// One bridge channel's receive run control with a self-clearing command pair.
// Assumes the receive engine acknowledges start and stop with one-cycle pulses.
`timescale 1ns/1ps
module rx_run_ctrl (
    input wire pclk,
    input wire presetn,
    input wire start_set,
    input wire stop_set,
    input wire start_ack,
    input wire stop_ack,
    output reg start_pend_q,
    output reg stop_pend_q,
    output reg running_q
);
    // A new write wins over an acknowledge arriving in the same cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_pend_q <= 1'b0;
            stop_pend_q <= 1'b0;
            running_q <= 1'b0;
        end else begin
            if (start_set) begin
                start_pend_q <= 1'b1;
            end else if (start_ack) begin
                start_pend_q <= 1'b0;
            end
            if (stop_set) begin
                stop_pend_q <= 1'b1;
            end else if (stop_ack) begin
                stop_pend_q <= 1'b0;
            end
            if (stop_ack) begin
                running_q <= 1'b0;
            end else if (start_ack) begin
                running_q <= 1'b1;
            end
        end
    end
endmodule // rx_run_ctrl

/* File: logic/chan_match.v */
// Compares a received packet's channel number with the programmed one.
// Assumes the packet channel and its valid strobe are synchronous to pclk.
`timescale 1ns/1ps
module chan_match #(
    parameter CH_W = 6
) (
    input wire pclk,
    input wire presetn,
    input wire enable,
    input wire pkt_valid,
    input wire [CH_W-1:0] pkt_channel,
    input wire [CH_W-1:0] want_channel,
    output reg accept_q
);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accept_q <= 1'b0;
        end else begin
            accept_q <= enable & pkt_valid & (pkt_channel == want_channel);
        end
    end
endmodule // chan_match

/* File: verification/isoch_bridge_header_config_monitor.sv */
// Port assertions for the bridge header register bank.
// Assumes a wait-free APB slave and pulsed receive acknowledges.
`timescale 1ns/1ps
`include "isoch_bridge_regs.vh"
module isoch_bridge_header_config_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire [5:0] tx_source_id_second,
    input wire [7:0] tx_block_size_second,
    input wire [1:0] tx_fraction_count_second,
    input wire [5:0] tx_format_code_second,
    input wire tx_time_shift_flag_second,
    input wire [5:0] tx_channel_second,
    input wire [1:0] tx_speed_second,
    input wire tx_speed_reserved,
    input wire rx_started_b,
    input wire rx_start_req_b,
    input wire rx_stop_req_a,
    input wire rx_running_a,
    input wire rx_running_b,
    input wire pkt_valid,
    input wire rx_accept_a,
    input wire rx_accept_b
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A write counts only at the access edge where the slave answers.
    wire wr = psel & penable & pready & pwrite;
    wire wr_cmd = wr & (paddr == `OFS_RECEIVE_SETUP);
    wire [15:0] wd = pwdata[15:0];
    // The register loads at the write edge and the field outputs one edge later.
    property p_word_a;
        wr && paddr == `OFS_TX_HEADER_WORD_A |-> ##2
            {tx_source_id_second, tx_block_size_second,
            tx_fraction_count_second} == $past(wd, 2);
    endproperty
    property p_chan_speed;
        wr && paddr == `OFS_TX_CHANNEL_SPEED |-> ##2
            {tx_format_code_second, tx_time_shift_flag_second, tx_channel_second,
            tx_speed_second} == ($past(wd, 2) >> 1);
    endproperty
    chk_word_a_copy: assert property (p_word_a)
        else $error("header word fields not copied");
    chk_chan_speed_copy: assert property (p_chan_speed)
        else $error("channel speed fields not copied");
    chk_rsv_reads_zero: assert property (psel && penable && pready && !pwrite
        && paddr == `OFS_TX_CHANNEL_SPEED |-> prdata[0] == 1'b0)
        else $error("reserved bit read nonzero");
    chk_speed_rsvd_flag: assert property (
        tx_speed_reserved == (tx_speed_second == `SPEED_RSVD))
        else $error("reserved speed flag wrong");
    chk_start_b_set: assert property (wr_cmd && pwdata[15] |=> rx_start_req_b)
        else $error("second start request not raised");
    chk_start_b_clear: assert property (
        rx_started_b && !(wr_cmd && pwdata[15]) |=> !rx_start_req_b)
        else $error("second start request not cleared");
    chk_stop_a_set: assert property (wr_cmd && pwdata[6] |=> rx_stop_req_a)
        else $error("first stop request not raised");
    chk_accept_a_cause: assert property (
        rx_accept_a |-> $past(pkt_valid) && $past(rx_running_a))
        else $error("first accept without cause");
    chk_accept_b_cause: assert property (
        rx_accept_b |-> $past(pkt_valid) && $past(rx_running_b))
        else $error("second accept without cause");
    cov_start_b: cover property (wr_cmd && pwdata[15]);
    cov_accept_b: cover property (rx_accept_b);
    cov_speed_rsvd: cover property (tx_speed_reserved);
endmodule // isoch_bridge_header_config_monitor
bind isoch_bridge_header_config isoch_bridge_header_config_monitor mon (.*);

/* File: verification/tb.sv */
// Self-checking bench for the bridge header register bank over APB.
// Assumes the bank answers each access and takes acknowledge pulses.
`timescale 1ns/1ps
`include "isoch_bridge_regs.vh"
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pkt_valid, e;
    logic rx_started_a, rx_stopped_a, rx_started_b, rx_stopped_b, tx_speed_reserved;
    logic rx_start_req_a, rx_stop_req_a, rx_start_req_b, rx_stop_req_b;
    logic rx_running_a, rx_running_b, rx_accept_a, rx_accept_b, tx_time_shift_flag_second;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] pkt_channel, tx_source_id_second, tx_format_code_second, tx_channel_second;
    logic [7:0] tx_block_size_second;
    logic [1:0] tx_fraction_count_second, tx_speed_second;
    logic [15:0] va, vb;
    int fails = 0;
    int comparisons = 0;
    isoch_bridge_header_config DUT (.*);
    task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i < 16) begin
            rd = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end else begin
            fails++;
            conclude();
        end
    endtask
    task automatic ack(input logic stop);
        @(posedge pclk);
        {rx_stopped_a, rx_stopped_b} <= {2{stop}};
        {rx_started_a, rx_started_b} <= {2{!stop}};
        @(posedge pclk);
        {rx_started_a, rx_stopped_a, rx_started_b, rx_stopped_b} <= 4'h0;
        @(negedge pclk);
    endtask
    task automatic pkt(input logic [5:0] c, input logic ea, input logic eb);
        @(posedge pclk);
        pkt_valid <= 1'b1;
        pkt_channel <= c;
        @(posedge pclk);
        pkt_valid <= 1'b0;
        @(negedge pclk);
        check("accept_a", rx_accept_a, ea);
        check("accept_b", rx_accept_b, eb);
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, pkt_valid, presetn} = 5'h00;
        {rx_started_a, rx_stopped_a, rx_started_b, rx_stopped_b} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pkt_channel = 6'h00;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            apb(1'b0, 12'(4 * (`IDX_TX_HEADER_WORD_A + 2 * k)), 32'h0);
            check("reset error", e, 1'b0);
            check("reset value", rd, 32'h0);
        end
        // An unmapped write must leave the mapped registers alone.
        apb(1'b1, 12'h040, 32'hffff);
        check("unmapped error", e, 1'b1);
        apb(1'b0, `OFS_TX_HEADER_WORD_A, 32'h0);
        check("word a kept", rd, 32'h0);
        $display("test reset done");
        // Transport stream settings first, then the satellite format.
        for (int k = 0; k < 2; k++) begin
            va = {6'h15 + 6'(k), k ? 8'h09 : 8'h06, k ? 2'h2 : 2'h3};
            vb = {k ? 6'h21 : 6'h20, k[0], 6'h2a, 2'(k), 1'b0};
            apb(1'b1, `OFS_TX_HEADER_WORD_A, {16'h0, va});
            apb(1'b1, `OFS_TX_CHANNEL_SPEED, {16'h0, vb});
            repeat (2) @(negedge pclk);
            check("sid", tx_source_id_second, va[15:10]);
            check("dbs", tx_block_size_second, va[9:2]);
            check("fn", tx_fraction_count_second, va[1:0]);
            check("fmt", tx_format_code_second, vb[15:10]);
            check("tsf", tx_time_shift_flag_second, vb[9]);
            check("tx channel", tx_channel_second, vb[8:3]);
            apb(1'b0, `OFS_TX_HEADER_WORD_A, 32'h0);
            check("word a read", rd, {16'h0, va});
            apb(1'b0, `OFS_TX_CHANNEL_SPEED, 32'h0);
            check("chan speed read", rd, {16'h0, vb[15:1], 1'b0});
        end
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, `OFS_TX_CHANNEL_SPEED, {16'h0000, 13'h107f, 2'(s), 1'b0});
            repeat (2) @(negedge pclk);
            check("speed", tx_speed_second, s);
            check("speed reserved", tx_speed_reserved, s == 3);
        end
        $display("test header done");
        apb(1'b1, `OFS_RECEIVE_SETUP, 32'hac93);
        @(negedge pclk);
        check("start reqs", {rx_start_req_b, rx_start_req_a}, 2'h3);
        ack(1'b0);
        check("start cleared", {rx_start_req_b, rx_start_req_a}, 2'h0);
        check("running", {rx_running_b, rx_running_a}, 2'h3);
        apb(1'b0, `OFS_RECEIVE_SETUP, 32'h0);
        check("setup read", rd, 32'h2c13);
        pkt(6'h2c, 1'b0, 1'b1);
        pkt(6'h13, 1'b1, 1'b0);
        pkt(6'h00, 1'b0, 1'b0);
        apb(1'b1, `OFS_RECEIVE_SETUP, 32'h6c53);
        @(negedge pclk);
        check("stop reqs", {rx_stop_req_b, rx_stop_req_a}, 2'h3);
        ack(1'b1);
        check("stop cleared", {rx_stop_req_b, rx_stop_req_a}, 2'h0);
        check("stopped", {rx_running_b, rx_running_a}, 2'h0);
        pkt(6'h2c, 1'b0, 1'b0);
        $display("test receive done");
        conclude();
    end
endmodule // tb
